// ### pkg/rtc_pkg.sv
/*
 Package of the real-time counter register block: register offsets, field
 positions, reset values, the bus request carrier and the state record.
 Assumes one bus clock; tick sources arrive as slow levels from outside.
*/
package rtc_pkg;

   // Register offsets on the byte-wide register port
   localparam logic [4:0] OFF_CONTROL_A = 5'h00;
   localparam logic [4:0] OFF_SYNC_STATUS = 5'h01;
   localparam logic [4:0] OFF_IRQ_ENABLE = 5'h02;
   localparam logic [4:0] OFF_IRQ_FLAGS = 5'h03;
   localparam logic [4:0] OFF_LATCH = 5'h04;
   localparam logic [4:0] OFF_DEBUG_CONTROL = 5'h05;
   localparam logic [4:0] OFF_TICK_SOURCE = 5'h07;
   localparam logic [4:0] OFF_COUNT_LO = 5'h08;
   localparam logic [4:0] OFF_COUNT_HI = 5'h09;
   localparam logic [4:0] OFF_TOP_LO = 5'h0a;
   localparam logic [4:0] OFF_TOP_HI = 5'h0b;
   localparam logic [4:0] OFF_MATCH_LO = 5'h0c;
   localparam logic [4:0] OFF_MATCH_HI = 5'h0d;

   // Field positions
   localparam int BIT_COUNTER_ENABLE = 0;
   localparam int BIT_DIV_LO = 3;
   localparam int BIT_STANDBY_KEEP_RUNNING = 7;
   localparam int BIT_WRAP_EVENT = 0;
   localparam int BIT_MATCH_VALUE = 1;
   localparam logic [7:0] CONTROL_A_WRITABLE = 8'hf9;
   localparam logic [7:0] IRQ_WRITABLE = 8'h03;

   // Index of each pending update, equal to its busy bit in sync_status
   localparam int PEND_CONTROL = 0;
   localparam int PEND_COUNT = 1;
   localparam int PEND_TOP = 2;
   localparam int PEND_MATCH = 3;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic [15:0] RESET_TOP = 16'hffff;
   localparam logic [15:0] RESET_MATCH = 16'h0000;

   // Tick edges a written value waits before it acts on the counter
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   // Tick source codes
   localparam logic [1:0] SRC_ULP_32K = 2'h0;
   localparam logic [1:0] SRC_ULP_1K = 2'h1;
   localparam logic [1:0] SRC_CRYSTAL = 2'h2;
   localparam logic [1:0] SRC_EXT_PIN = 2'h3;

   // One register-port request
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rtc_bus_req_s;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] controlA;     // As written by software
      logic [7:0] controlTick;  // As seen by the counter
      logic [1:0] tickSource;
      logic haltKeepRunning;
      logic [1:0] irqEnable;
      logic [1:0] irqFlags;
      logic [7:0] latch;
      logic [15:0] countShadow;
      logic [15:0] topShadow;
      logic [15:0] matchShadow;
      logic [15:0] countValue;
      logic [15:0] wrapTopValue;
      logic [15:0] matchValue;
      logic [3:0][1:0] pend;
      logic [14:0] prescale;
      logic [3:0] syncA;
      logic [3:0] syncB;
      logic tickPrev;
      logic [7:0] rdata;
      logic irq;
      logic wrapEvent;
      logic matchEvent;
   } rtc_state_s;

endpackage

// ### rtl/rtc_counter_register_block.sv
/*
 Real-time counter with byte-wide register port, tick source selection,
 prescaler, wrap and match flags, events and one interrupt request.
 Assumes tick source levels come from other clock domains and are slower
 than half the bus clock; standby and debug halt come from bus-clock logic.
*/
module rtc_counter_register_block (
   input wire logic clk,                         // Bus clock, 100 MHz
   input wire logic reset_n,                     // Asynchronous reset, active low
   input wire rtc_pkg::rtc_bus_req_s busReq,     // Register port request
   output logic [7:0] busRdata,                  // Read data, cycle after read
   input wire logic [3:0] tickSourcePins,        // ULP 32k, ULP 1k, crystal, external pin
   input wire logic standbySleep,                // Device is in standby sleep
   input wire logic debugHalt,                   // CPU halted in break debug mode
   output logic irqRequest,                      // Interrupt request level
   output logic wrapEventOut,                    // One-cycle wrap event
   output logic matchEventOut                    // One-cycle match event
);

   rtc_pkg::rtc_state_s s;
   rtc_pkg::rtc_state_s next_s;

   // Next-state logic of the whole block
   always_comb begin
      logic tickLevel;
      logic tickEdge;
      logic tick;
      logic run;
      logic step;
      logic [14:0] mask;
      logic [1:0] setFlags;
      logic [1:0] clrFlags;
      logic [15:0] stepped;
      tickLevel = 1'b0;
      tickEdge = 1'b0;
      tick = 1'b0;
      run = 1'b0;
      step = 1'b0;
      mask = 15'h0000;
      setFlags = 2'h0;
      clrFlags = 2'h0;
      stepped = 16'h0000;
      next_s = s;
      next_s.rdata = rtc_pkg::RESET_BYTE;
      next_s.wrapEvent = 1'b0;
      next_s.matchEvent = 1'b0;

      // Two flip-flops per source before any selection touches them
      next_s.syncA = tickSourcePins;
      next_s.syncB = s.syncA;
      tickLevel = s.syncB[s.tickSource];
      next_s.tickPrev = tickLevel;
      tickEdge = tickLevel & ~s.tickPrev;
      tick = tickEdge & ~(debugHalt & ~s.haltKeepRunning);

      // Counting path in tick terms
      run = s.controlTick[rtc_pkg::BIT_COUNTER_ENABLE]
         & ~(standbySleep & ~s.controlTick[rtc_pkg::BIT_STANDBY_KEEP_RUNNING]);
      mask = 15'((16'h0001 << s.controlTick[6:3]) - 16'h0001);
      if (!run) begin
         next_s.prescale = 15'h0000;
      end else if (tick) begin
         next_s.prescale = s.prescale + 15'h0001;
         step = (s.prescale & mask) == mask;
      end
      if (step) begin
         if (s.countValue == s.wrapTopValue) begin
            stepped = 16'h0000;
            setFlags[rtc_pkg::BIT_WRAP_EVENT] = 1'b1;
         end else begin
            stepped = s.countValue + 16'h0001;
         end
         next_s.countValue = stepped;
         setFlags[rtc_pkg::BIT_MATCH_VALUE] = (stepped == s.matchValue);
      end

      // Pending updates move one step per tick edge; halted ticks do not count
      for (int i = 0; i < 4; i++) begin
         if (tick && s.pend[i] != 2'h0) begin
            next_s.pend[i] = s.pend[i] - 2'h1;
            if (s.pend[i] == 2'h1) begin
               case (i)
                  rtc_pkg::PEND_CONTROL: next_s.controlTick = s.controlA;
                  rtc_pkg::PEND_COUNT: next_s.countValue = s.countShadow;
                  rtc_pkg::PEND_TOP: next_s.wrapTopValue = s.topShadow;
                  default: next_s.matchValue = s.matchShadow;
               endcase
            end
         end
      end

      // Register writes; a pending update restarts if rewritten early
      if (busReq.wr) begin
         if (busReq.addr == rtc_pkg::OFF_CONTROL_A) begin
            next_s.controlA = busReq.wdata & rtc_pkg::CONTROL_A_WRITABLE;
            next_s.pend[rtc_pkg::PEND_CONTROL] = rtc_pkg::SYNC_TICKS;
         end else if (busReq.addr == rtc_pkg::OFF_IRQ_ENABLE) begin
            next_s.irqEnable = busReq.wdata[1:0];
         end else if (busReq.addr == rtc_pkg::OFF_IRQ_FLAGS) begin
            clrFlags = busReq.wdata[1:0];
         end else if (busReq.addr == rtc_pkg::OFF_LATCH) begin
            next_s.latch = busReq.wdata;
         end else if (busReq.addr == rtc_pkg::OFF_DEBUG_CONTROL) begin
            next_s.haltKeepRunning = busReq.wdata[0];
         end else if (busReq.addr == rtc_pkg::OFF_TICK_SOURCE) begin
            next_s.tickSource = busReq.wdata[1:0];
         end else if (busReq.addr == rtc_pkg::OFF_COUNT_LO
            || busReq.addr == rtc_pkg::OFF_TOP_LO
            || busReq.addr == rtc_pkg::OFF_MATCH_LO) begin
            next_s.latch = busReq.wdata;
         end else if (busReq.addr == rtc_pkg::OFF_COUNT_HI) begin
            next_s.countShadow = {busReq.wdata, s.latch};
            next_s.pend[rtc_pkg::PEND_COUNT] = rtc_pkg::SYNC_TICKS;
         end else if (busReq.addr == rtc_pkg::OFF_TOP_HI) begin
            next_s.topShadow = {busReq.wdata, s.latch};
            next_s.pend[rtc_pkg::PEND_TOP] = rtc_pkg::SYNC_TICKS;
         end else if (busReq.addr == rtc_pkg::OFF_MATCH_HI) begin
            next_s.matchShadow = {busReq.wdata, s.latch};
            next_s.pend[rtc_pkg::PEND_MATCH] = rtc_pkg::SYNC_TICKS;
         end
      end

      // Register reads; unmapped offsets read zero
      if (busReq.rd) begin
         if (busReq.addr == rtc_pkg::OFF_CONTROL_A) begin
            next_s.rdata = s.controlA;
         end else if (busReq.addr == rtc_pkg::OFF_SYNC_STATUS) begin
            for (int i = 0; i < 4; i++) begin
               next_s.rdata[i] = s.pend[i] != 2'h0;
            end
         end else if (busReq.addr == rtc_pkg::OFF_IRQ_ENABLE) begin
            next_s.rdata = {6'h00, s.irqEnable};
         end else if (busReq.addr == rtc_pkg::OFF_IRQ_FLAGS) begin
            next_s.rdata = {6'h00, s.irqFlags};
         end else if (busReq.addr == rtc_pkg::OFF_LATCH) begin
            next_s.rdata = s.latch;
         end else if (busReq.addr == rtc_pkg::OFF_DEBUG_CONTROL) begin
            next_s.rdata = {7'h00, s.haltKeepRunning};
         end else if (busReq.addr == rtc_pkg::OFF_TICK_SOURCE) begin
            next_s.rdata = {6'h00, s.tickSource};
         end else if (busReq.addr == rtc_pkg::OFF_COUNT_LO) begin
            next_s.rdata = s.countValue[7:0];
            next_s.latch = s.countValue[15:8];
         end else if (busReq.addr == rtc_pkg::OFF_TOP_LO) begin
            next_s.rdata = s.topShadow[7:0];
            next_s.latch = s.topShadow[15:8];
         end else if (busReq.addr == rtc_pkg::OFF_MATCH_LO) begin
            next_s.rdata = s.matchShadow[7:0];
            next_s.latch = s.matchShadow[15:8];
         end else if (busReq.addr == rtc_pkg::OFF_COUNT_HI
            || busReq.addr == rtc_pkg::OFF_TOP_HI
            || busReq.addr == rtc_pkg::OFF_MATCH_HI) begin
            next_s.rdata = s.latch;
         end
      end

      // A hardware set in the clearing cycle wins, so no event is lost
      next_s.irqFlags = (s.irqFlags & ~clrFlags) | setFlags;
      next_s.wrapEvent = setFlags[rtc_pkg::BIT_WRAP_EVENT];
      next_s.matchEvent = setFlags[rtc_pkg::BIT_MATCH_VALUE];
      next_s.irq = |(next_s.irqFlags & next_s.irqEnable);
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.countValue <= rtc_pkg::RESET_COUNT;
         s.countShadow <= rtc_pkg::RESET_COUNT;
         s.wrapTopValue <= rtc_pkg::RESET_TOP;
         s.topShadow <= rtc_pkg::RESET_TOP;
         s.matchValue <= rtc_pkg::RESET_MATCH;
         s.matchShadow <= rtc_pkg::RESET_MATCH;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign busRdata = s.rdata;
   assign irqRequest = s.irq;
   assign wrapEventOut = s.wrapEvent;
   assign matchEventOut = s.matchEvent;

endmodule

// ### testbench/rtc_counter_register_block_bench.sv
/*
 Self-checking bench for the real-time counter register block.
 Assumes the checker is bound in; the bench makes ticks on the source pins.
*/
module rtc_counter_register_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   rtc_pkg::rtc_bus_req_s busReq = '0;
   logic [7:0] busRdata;
   logic [3:0] tickSourcePins = 4'h0;
   logic standbySleep = 1'b0;
   logic debugHalt = 1'b0;
   logic irqRequest, wrapEventOut, matchEventOut;
   int mismatches = 0;
   int check_count = 0;
   int expC;
   int wrapCnt = 0;
   int matchCnt = 0;
   localparam logic [4:0] OFFS [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07,
      5'h08, 5'h0a, 5'h04, 5'h06};
   localparam logic [7:0] RESV [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hff, 8'hff, 8'h00};
   // 100 MHz bus clock
   always #5 clk = ~clk;
   // Event pulses are counted so each one-cycle pulse is seen
   always @(posedge clk) begin
      if (wrapEventOut) wrapCnt <= wrapCnt + 1;
      if (matchEventOut) matchCnt <= matchCnt + 1;
   end
   rtc_counter_register_block i_rtc_counter_register_block (.clk(clk), .reset_n(reset_n),
      .busReq(busReq), .busRdata(busRdata), .tickSourcePins(tickSourcePins),
      .standbySleep(standbySleep), .debugHalt(debugHalt), .irqRequest(irqRequest),
      .wrapEventOut(wrapEventOut), .matchEventOut(matchEventOut));
   task automatic end_of_test();
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Write strobe stays up until the next request replaces it
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, d, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      busReq <= '0;
      #1 check($sformatf("offset %h", a), busRdata, exp);
   endtask
   // Slow ticks: the synchroniser needs several bus cycles per level
   task automatic ticks(input int pin, input int n);
      @(posedge clk);
      busReq <= '0;
      repeat (n) begin
         repeat (4) @(posedge clk);
         tickSourcePins[pin] <= 1'b1;
         repeat (4) @(posedge clk);
         tickSourcePins[pin] <= 1'b0;
      end
      repeat (5) @(posedge clk);
   endtask
   task automatic irq(input logic exp);
      check("irq", {7'h00, irqRequest}, {7'h00, exp});
   endtask
   // Watchdog cuts a hang short
   initial begin
      #500us mismatches++;
      end_of_test();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 11; i++) rd(OFFS[i], RESV[i]);
      wr(rtc_pkg::OFF_LATCH, 8'ha5);
      rd(rtc_pkg::OFF_LATCH, 8'ha5);
      wr(rtc_pkg::OFF_TOP_LO, 8'h03);
      wr(rtc_pkg::OFF_TOP_HI, 8'h00);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h04);
      ticks(0, 1);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h04);
      ticks(0, 1);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h00);
      wr(rtc_pkg::OFF_MATCH_LO, 8'h02);
      wr(rtc_pkg::OFF_MATCH_HI, 8'h00);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h08);
      ticks(0, 2);
      wr(rtc_pkg::OFF_IRQ_ENABLE, 8'hff);
      rd(rtc_pkg::OFF_IRQ_ENABLE, 8'h03);
      wr(rtc_pkg::OFF_CONTROL_A, 8'h07);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h01);
      ticks(0, 1);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h01);
      ticks(0, 1);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h00);
      rd(rtc_pkg::OFF_CONTROL_A, 8'h01);
      wr(rtc_pkg::OFF_COUNT_LO, 8'h00);
      wr(rtc_pkg::OFF_COUNT_HI, 8'h00);
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h02);
      ticks(0, 2);
      wr(rtc_pkg::OFF_IRQ_FLAGS, 8'h03);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h00);
      ticks(0, 1);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h01);
      ticks(0, 1);
      rd(rtc_pkg::OFF_IRQ_FLAGS, 8'h02);
      irq(1'b1);
      wr(rtc_pkg::OFF_IRQ_FLAGS, 8'h01);
      rd(rtc_pkg::OFF_IRQ_FLAGS, 8'h02);
      wr(rtc_pkg::OFF_IRQ_FLAGS, 8'h02);
      rd(rtc_pkg::OFF_IRQ_FLAGS, 8'h00);
      irq(1'b0);
      ticks(0, 2);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h00);
      rd(rtc_pkg::OFF_IRQ_FLAGS, 8'h01);
      irq(1'b1);
      check("wrap events", 8'(wrapCnt), 8'h01);
      check("match events", 8'(matchCnt), 8'h02);
      wr(rtc_pkg::OFF_IRQ_ENABLE, 8'h02);
      rd(rtc_pkg::OFF_IRQ_FLAGS, 8'h01);
      irq(1'b0);
      wr(rtc_pkg::OFF_IRQ_FLAGS, 8'h01);
      // Divide by two, then restart the count from zero
      wr(rtc_pkg::OFF_CONTROL_A, 8'h09);
      ticks(0, 2);
      wr(rtc_pkg::OFF_COUNT_LO, 8'h00);
      wr(rtc_pkg::OFF_COUNT_HI, 8'h00);
      ticks(0, 6);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h02);
      expC = 2;
      for (int s = 0; s < 4; s++) begin
         wr(rtc_pkg::OFF_TICK_SOURCE, 8'(s));
         rd(rtc_pkg::OFF_TICK_SOURCE, 8'(s));
         ticks((s + 1) % 4, 2);
         rd(rtc_pkg::OFF_COUNT_LO, 8'(expC));
         ticks(s, 2);
         expC = (expC + 1) % 4;
         rd(rtc_pkg::OFF_COUNT_LO, 8'(expC));
      end
      @(posedge clk) standbySleep <= 1'b1;
      ticks(3, 4);
      rd(rtc_pkg::OFF_COUNT_LO, 8'(expC));
      rd(rtc_pkg::OFF_SYNC_STATUS, 8'h00);
      wr(rtc_pkg::OFF_CONTROL_A, 8'h89);
      wr(rtc_pkg::OFF_COUNT_LO, 8'h00);
      wr(rtc_pkg::OFF_COUNT_HI, 8'h00);
      ticks(3, 6);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h02);
      @(posedge clk) standbySleep <= 1'b0;
      debugHalt <= 1'b1;
      ticks(3, 4);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h02);
      wr(rtc_pkg::OFF_DEBUG_CONTROL, 8'hff);
      rd(rtc_pkg::OFF_DEBUG_CONTROL, 8'h01);
      ticks(3, 4);
      rd(rtc_pkg::OFF_COUNT_LO, 8'h00);
      end_of_test();
   end
endmodule

// ### testbench/rtc_counter_register_block_checker.sv
/*
 Port checker for the real-time counter register block.
 Assumes the block's ports only; attached to every instance by bind.
*/
module rtc_counter_register_block_checker (
   input wire logic clk,                      // Bus clock
   input wire logic reset_n,                  // Async reset, active low
   input wire rtc_pkg::rtc_bus_req_s busReq,  // Register port request
   input wire logic [7:0] busRdata,           // Read data
   input wire logic wrapEventOut,             // Wrap event pulse
   input wire logic matchEventOut             // Match event pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // A write followed at once by a status read; no two ticks fit between
   sequence wr_then_status(logic [4:0] a);
      busReq.wr && busReq.addr == a ##1 busReq.rd && busReq.addr == rtc_pkg::OFF_SYNC_STATUS;
   endsequence
   a_ctrl_busy_shown: assert property (wr_then_status(rtc_pkg::OFF_CONTROL_A) |=> busRdata[0])
      else $error("control busy not shown");
   a_count_busy_shown: assert property (wr_then_status(rtc_pkg::OFF_COUNT_HI) |=> busRdata[1])
      else $error("count busy not shown");
   a_top_busy_shown: assert property (wr_then_status(rtc_pkg::OFF_TOP_HI) |=> busRdata[2])
      else $error("top busy not shown");
   a_match_busy_shown: assert property (wr_then_status(rtc_pkg::OFF_MATCH_HI) |=> busRdata[3])
      else $error("match busy not shown");
   a_status_upper_zero: assert property (busReq.rd && busReq.addr == rtc_pkg::OFF_SYNC_STATUS
      |=> busRdata[7:4] == 4'h0) else $error("status upper bits set");
   a_latch_direct: assert property (busReq.wr && busReq.addr == rtc_pkg::OFF_LATCH ##1 busReq.rd
      && busReq.addr == rtc_pkg::OFF_LATCH |=> busRdata == $past(busReq.wdata, 2))
      else $error("latch read differs from write");
   a_rdata_only_after_read: assert property (busRdata != 8'h00 |-> $past(busReq.rd))
      else $error("read data outside read answer");
   a_wrap_single_pulse: assert property (wrapEventOut |=> !wrapEventOut)
      else $error("wrap event longer than one cycle");
   a_match_single_pulse: assert property (matchEventOut |=> !matchEventOut)
      else $error("match event longer than one cycle");
endmodule

bind rtc_counter_register_block rtc_counter_register_block_checker
   i_rtc_counter_register_block_checker (.clk(clk),
   .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata), .wrapEventOut(wrapEventOut),
   .matchEventOut(matchEventOut));
